// File: verilog/crs_register_set.v
// Programmer-visible register set of a 16-bit core, with a core port and an AXI4-Lite port.
// Assumes one clock, a synchronous active-high reset and an execution datapath on the same clock.
//
// Functional notes
// - Four 16-bit data registers, readable and writable as operands and destinations.
// - Data registers zero and one split into independently writable high and low bytes.
// - Pairs two/zero and three/one read and write as 32-bit values, upper in two/three.
// - Two 16-bit address registers, usable for addressing and ordinary operations.
// - Address registers one/zero combine into one 32-bit register, one on top.
// - A 16-bit frame base register feeds frame-relative addressing.
// - A 20-bit vector table base register gives the interrupt table start.
// - A 20-bit program counter holds the next instruction address.
// - Separate user and interrupt 16-bit stack pointers, chosen by the stack flag.
// - A 16-bit static base register feeds static-base-relative addressing.
// - Address registers hold 16 bits; frame and static base outputs are zero-extended to 20 bits.
// - Stack flag zero selects interrupt pointer; flag one selects user pointer.
// - Acknowledging a hardware interrupt clears the stack flag.
// - Bank flag zero selects bank zero; flag one selects bank one.
//
// The address map and register access over AXI4-Lite were decided locally.
`include "crs_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module crs_register_set
#(
    parameter DATA_W = 16,
    parameter ADDR_W = 20
)
(
    input  wire                ref_clk,
    input  wire                reset,
    input  wire                clk_en,
    input  wire                core_wr_en,
    input  wire [2:0]          core_wr_sel,
    input  wire [1:0]          core_wr_bytes,
    input  wire [DATA_W-1:0]   core_wr_data,
    input  wire                core_long_wr_en,
    input  wire [1:0]          core_long_wr_sel,
    input  wire [2*DATA_W-1:0] core_long_wr_data,
    input  wire                core_sp_wr_en,
    input  wire [DATA_W-1:0]   core_sp_wr_data,
    input  wire                core_vector_wr_en,
    input  wire [ADDR_W-1:0]   core_vector_wr_data,
    input  wire                core_pc_wr_en,
    input  wire [ADDR_W-1:0]   core_pc_wr_data,
    input  wire                core_flag_wr_en,
    input  wire [10:0]         core_flag_wr_data,
    input  wire                core_hw_int_ack,
    input  wire [2:0]          core_rd_sel,
    output reg  [DATA_W-1:0]   core_rd_data,
    output wire [2*DATA_W-1:0] data_pair_low_long,
    output wire [2*DATA_W-1:0] data_pair_high_long,
    output wire [2*DATA_W-1:0] address_pair_long,
    output wire [ADDR_W-1:0]   frame_base_addr,
    output wire [ADDR_W-1:0]   static_base_addr,
    output wire [ADDR_W-1:0]   vector_table_base,
    output wire [ADDR_W-1:0]   program_counter,
    output wire [DATA_W-1:0]   active_stack_pointer,
    output wire                register_bank,
    output wire [10:0]         cpu_flag_register,
    input  wire [11:0]         s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [11:0]         s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    // Slots 0 to 3 are data, 4 and 5 address, 6 frame base and 7 static base.
    reg  [DATA_W-1:0] gp_reg [0:7];
    reg  [ADDR_W-1:0] vector_reg;
    reg  [ADDR_W-1:0] pc_reg;
    reg  [DATA_W-1:0] usp_reg;
    reg  [DATA_W-1:0] isp_reg;
    reg  [10:0]       flag_reg;

    // ****************************************************************
    // AXI4-Lite write capture
    // ****************************************************************
    reg               aw_held_reg;
    reg  [11:0]       aw_addr_reg;
    reg               w_held_reg;
    reg  [31:0]       w_data_reg;
    reg  [3:0]        w_strb_reg;

    // Ready stays low while the clock enable is low, so that a master never
    // sees an address or write-data handshake on an edge at which the registers are frozen.
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid && clk_en;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid && clk_en;
    assign s_axi_arready = !s_axi_rvalid && clk_en;

    wire        bus_wr_go = aw_held_reg && w_held_reg && clk_en;
    wire [11:0] wa        = aw_addr_reg;
    wire [31:0] wd        = w_data_reg;
    wire [3:0]  ws        = w_strb_reg;

    // A bus write lands only on an aligned word of a writable register.
    function wr_hit;
        input [11:0] addr;
        begin
            wr_hit = (addr[1:0] == 2'h0) && (addr <= `CRS_OFF_ACTIVE_SP) &&
                     (addr != `CRS_OFF_PC) && (addr != `CRS_OFF_ACTIVE_SP);
        end
    endfunction

    // Merge 16 bits of bus data under byte strobes into an old value.
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  stb;
        begin
            merge16 = {stb[1] ? nw[15:8] : old[15:8], stb[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // The stack select flag picks the user pointer when high, the interrupt one when low.
    wire stack_user = flag_reg[`CRS_FLAG_STACK_BIT];

    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            aw_held_reg  <= 1'b0;
            aw_addr_reg  <= 12'h000;
            w_held_reg   <= 1'b0;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CRS_RESP_OKAY;
        end
        else if (clk_en)
        begin
            // Address and data may arrive in either order; each waits in its holder.
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            // Using both halves frees the holders and raises the response.
            if (bus_wr_go)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit(wa) ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // General registers: core writes take priority over bus writes
    // ****************************************************************
    // Each general register picks its own write source, highest priority first.
    // A long write with selector two is unused and changes no register.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_gp
            localparam [2:0]  MY_SEL = gi;
            localparam [11:0] MY_OFF = {7'h00, MY_SEL, 2'h0};
            wire core_hit = core_wr_en && (core_wr_sel == MY_SEL);
            // Long writes land on the pair this register belongs to.
            wire long_lo = core_long_wr_en && (gi == 0)
                           && (core_long_wr_sel == 2'h0);
            wire long_hi = core_long_wr_en && (gi >= 2) && (gi < 4)
                           && (core_long_wr_sel == MY_SEL[1:0] - 2'h2);
            wire long_ad_lo = core_long_wr_en && (gi == 4) && (core_long_wr_sel == 2'h3);
            wire long_ad_hi = core_long_wr_en && (gi == 5) && (core_long_wr_sel == 2'h3);
            wire long_d_lo  = core_long_wr_en && (gi == 1) && (core_long_wr_sel == 2'h1);
            always @(posedge ref_clk)
            begin
                if (reset)
                    gp_reg[gi] <= `CRS_RST_WORD;
                else if (clk_en)
                begin
                    if (long_lo || long_d_lo || long_ad_lo)
                        gp_reg[gi] <= core_long_wr_data[15:0];
                    else if (long_hi || long_ad_hi)
                        gp_reg[gi] <= core_long_wr_data[31:16];
                    else if (core_hit && (gi < 2))
                        gp_reg[gi] <= merge16(gp_reg[gi], core_wr_data,
                                              core_wr_bytes);
                    else if (core_hit)
                        gp_reg[gi] <= core_wr_data;
                    else if (bus_wr_go && (wa == MY_OFF))
                        gp_reg[gi] <= merge16(gp_reg[gi], wd[15:0], ws[1:0]);
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Vector base, program counter, stack pointers and flags
    // ****************************************************************
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            vector_reg <= `CRS_RST_ADDR20;
            pc_reg     <= `CRS_RST_ADDR20;
            usp_reg    <= `CRS_RST_WORD;
            isp_reg    <= `CRS_RST_WORD;
            flag_reg   <= `CRS_RST_FLAG;
        end
        else if (clk_en)
        begin
            // Core writes beat bus writes; a bus write lost this way still gets its response.
            if (core_vector_wr_en)
                vector_reg <= core_vector_wr_data;
            else if (bus_wr_go && (wa == `CRS_OFF_VECTOR))
                vector_reg <= {ws[2] ? wd[19:16] : vector_reg[19:16],
                               merge16(vector_reg[15:0], wd[15:0], ws[1:0])};
            // Only the core loads the program counter; the bus can just read it.
            if (core_pc_wr_en)
                pc_reg <= core_pc_wr_data;
            // A stack pointer write from the core goes to the active pointer.
            if (core_sp_wr_en && stack_user)
                usp_reg <= core_sp_wr_data;
            else if (bus_wr_go && (wa == `CRS_OFF_USP))
                usp_reg <= merge16(usp_reg, wd[15:0], ws[1:0]);
            if (core_sp_wr_en && !stack_user)
                isp_reg <= core_sp_wr_data;
            else if (bus_wr_go && (wa == `CRS_OFF_ISP))
                isp_reg <= merge16(isp_reg, wd[15:0], ws[1:0]);
            // The acknowledge clears the stack flag even when a core flag write lands in the same cycle, and drops a bus flag write.
            if (core_hw_int_ack)
            begin
                if (core_flag_wr_en)
                    flag_reg <= core_flag_wr_data & ~(11'h001 << `CRS_FLAG_STACK_BIT);
                else
                    flag_reg[`CRS_FLAG_STACK_BIT] <= 1'b0;
            end
            else if (core_flag_wr_en)
                flag_reg <= core_flag_wr_data;
            // Bus data above the eleven flag bits are ignored.
            else if (bus_wr_go && (wa == `CRS_OFF_FLAG))
                flag_reg <= {ws[1] ? wd[10:8] : flag_reg[10:8],
                             ws[0] ? wd[7:0] : flag_reg[7:0]};
        end
    end

    // ****************************************************************
    // Core-side views
    // ****************************************************************
    assign data_pair_low_long   = {gp_reg[2], gp_reg[0]};
    assign data_pair_high_long  = {gp_reg[3], gp_reg[1]};
    assign address_pair_long    = {gp_reg[5], gp_reg[4]};
    // The base registers are zero-extended to the full address width.
    assign frame_base_addr      = {4'h0, gp_reg[6]};
    assign static_base_addr     = {4'h0, gp_reg[7]};
    assign vector_table_base    = vector_reg;
    assign program_counter      = pc_reg;
    assign active_stack_pointer = stack_user ? usp_reg : isp_reg;
    assign register_bank        = flag_reg[`CRS_FLAG_BANK_BIT];
    assign cpu_flag_register    = flag_reg;

    // The core reads any general register without waiting for an edge.
    always @*
    begin
        core_rd_data = gp_reg[core_rd_sel];
    end

    // ****************************************************************
    // AXI4-Lite read
    // ****************************************************************
    // The read mux follows the address while it is offered.
    reg [31:0] rd_mux;
    reg        rd_ok;

    always @*
    begin
        rd_ok  = 1'b1;
        rd_mux = 32'h00000000;
        // Unmapped offsets answer with an error and zero data.
        case (s_axi_araddr)
            `CRS_OFF_DATA0:     rd_mux = {16'h0000, gp_reg[0]};
            `CRS_OFF_DATA1:     rd_mux = {16'h0000, gp_reg[1]};
            `CRS_OFF_DATA2:     rd_mux = {16'h0000, gp_reg[2]};
            `CRS_OFF_DATA3:     rd_mux = {16'h0000, gp_reg[3]};
            `CRS_OFF_ADDR0:     rd_mux = {16'h0000, gp_reg[4]};
            `CRS_OFF_ADDR1:     rd_mux = {16'h0000, gp_reg[5]};
            `CRS_OFF_FRAME:     rd_mux = {16'h0000, gp_reg[6]};
            `CRS_OFF_STATIC:    rd_mux = {16'h0000, gp_reg[7]};
            `CRS_OFF_VECTOR:    rd_mux = {12'h000, vector_reg};
            `CRS_OFF_PC:        rd_mux = {12'h000, pc_reg};
            `CRS_OFF_USP:       rd_mux = {16'h0000, usp_reg};
            `CRS_OFF_ISP:       rd_mux = {16'h0000, isp_reg};
            `CRS_OFF_FLAG:      rd_mux = {21'h00000, flag_reg};
            `CRS_OFF_ACTIVE_SP: rd_mux = {16'h0000, active_stack_pointer};
            default:            rd_ok  = 1'b0;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `CRS_RESP_OKAY;
        end
        else if (clk_en)
        begin
            // Data are captured with the address and stand until rready.
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? `CRS_RESP_OKAY : `CRS_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // crs_register_set

`default_nettype wire

// File: verilog/crs_defines.vh
// Constants for the core register set: register offsets, widths, flag bits and reset values.
// Assumes inclusion by bare name from the register-set module.
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

`define CRS_OFF_DATA0      12'h000
`define CRS_OFF_DATA1      12'h004
`define CRS_OFF_DATA2      12'h008
`define CRS_OFF_DATA3      12'h00C
`define CRS_OFF_ADDR0      12'h010
`define CRS_OFF_ADDR1      12'h014
`define CRS_OFF_FRAME      12'h018
`define CRS_OFF_STATIC     12'h01C
`define CRS_OFF_VECTOR     12'h020
`define CRS_OFF_PC         12'h024
`define CRS_OFF_USP        12'h028
`define CRS_OFF_ISP        12'h02C
`define CRS_OFF_FLAG       12'h030
`define CRS_OFF_ACTIVE_SP  12'h034

`define CRS_FLAG_BANK_BIT  4
`define CRS_FLAG_STACK_BIT 7
`define CRS_FLAG_WIDTH     11

`define CRS_RST_WORD       16'h0000
`define CRS_RST_ADDR20     20'h00000
`define CRS_RST_FLAG       11'h000

`define CRS_RESP_OKAY      2'h0
`define CRS_RESP_SLVERR    2'h2

`define CRS_SEL_DATA0      3'h0
`define CRS_SEL_DATA1      3'h1
`define CRS_SEL_DATA2      3'h2
`define CRS_SEL_DATA3      3'h3
`define CRS_SEL_ADDR0      3'h4
`define CRS_SEL_ADDR1      3'h5
`define CRS_SEL_FRAME      3'h6
`define CRS_SEL_STATIC     3'h7

`define CRS_BYTE_LOW       2'h1
`define CRS_BYTE_HIGH      2'h2
`define CRS_BYTE_WORD      2'h3

`endif

// File: tb/crs_chk.sv
// Concurrent checks on the ports of the core register set.
// Assumes a bind to crs_register_set at its default widths.
`timescale 1ns/100ps
`default_nettype none
module crs_chk
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic        core_wr_en,
    input wire logic [2:0]  core_wr_sel,
    input wire logic [1:0]  core_wr_bytes,
    input wire logic [15:0] core_wr_data,
    input wire logic        core_long_wr_en,
    input wire logic [1:0]  core_long_wr_sel,
    input wire logic [31:0] core_long_wr_data,
    input wire logic        core_pc_wr_en,
    input wire logic [19:0] core_pc_wr_data,
    input wire logic        core_hw_int_ack,
    input wire logic [31:0] data_pair_low_long,
    input wire logic [31:0] data_pair_high_long,
    input wire logic [31:0] address_pair_long,
    input wire logic [19:0] program_counter,
    input wire logic        register_bank,
    input wire logic [10:0] cpu_flag_register,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    wire w0 = clk_en && core_wr_en && !core_long_wr_en;
    wire l0 = clk_en && core_long_wr_en;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    property p_lo;
        w0 && core_wr_sel == 3'h0 && core_wr_bytes == 2'h1 |=>
            data_pair_low_long[7:0] == $past(core_wr_data[7:0])
            && $stable(data_pair_low_long[15:8]);
    endproperty
    a_lo: assert property (p_lo) else $error("low byte write wrong");
    property p_hi;
        w0 && core_wr_sel == 3'h1 && core_wr_bytes == 2'h2 |=>
            data_pair_high_long[15:8] == $past(core_wr_data[15:8])
            && $stable(data_pair_high_long[7:0]);
    endproperty
    a_hi: assert property (p_hi) else $error("high byte write wrong");
    property p_wd;
        w0 && core_wr_sel == 3'h3 |=> data_pair_high_long[31:16] == $past(core_wr_data);
    endproperty
    a_wd: assert property (p_wd) else $error("word write wrong");
    property p_lng;
        l0 && core_long_wr_sel == 2'h0 |=> data_pair_low_long == $past(core_long_wr_data);
    endproperty
    a_lng: assert property (p_lng) else $error("long data write wrong");
    property p_adr;
        l0 && core_long_wr_sel == 2'h3 |=> address_pair_long == $past(core_long_wr_data);
    endproperty
    a_adr: assert property (p_adr) else $error("long address write wrong");
    property p_ack;
        clk_en && core_hw_int_ack |=> !cpu_flag_register[7];
    endproperty
    a_ack: assert property (p_ack) else $error("stack flag kept on ack");
    property p_bank;
        register_bank == cpu_flag_register[4];
    endproperty
    a_bank: assert property (p_bank) else $error("bank output wrong");
    property p_pc;
        clk_en && core_pc_wr_en |=> program_counter == $past(core_pc_wr_data);
    endproperty
    a_pc: assert property (p_pc) else $error("counter load wrong");
    property p_rd;
        clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
endmodule // crs_chk
bind crs_register_set crs_chk u_chk (.*);
`default_nettype wire

// File: tb/crs_core_model.sv
// Behavioural execution datapath that drives the core port of the register set.
// Assumes the bench calls op right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module crs_core_model
(
    input  wire logic        ref_clk,
    output var  logic        core_wr_en,
    output var  logic [2:0]  core_wr_sel,
    output var  logic [1:0]  core_wr_bytes,
    output var  logic [15:0] core_wr_data,
    output var  logic        core_long_wr_en,
    output var  logic [1:0]  core_long_wr_sel,
    output var  logic [31:0] core_long_wr_data,
    output var  logic [4:0]  misc_en,
    output var  logic [19:0] misc_data
);
    initial
    begin
        core_wr_en = 1'b0;
        core_long_wr_en = 1'b0;
        misc_en = 5'h00;
    end
    // Kind 0 is a short write, 1 a long write, 2 to 6 sp, vector, pc, flag, ack.
    task op(input logic [3:0] k, input logic [2:0] s, input logic [1:0] b,
            input logic [31:0] d);
        @(posedge ref_clk);
        core_wr_en <= (k == 4'h0);
        core_long_wr_en <= (k == 4'h1);
        misc_en <= (k > 4'h1) ? (5'h01 << (k - 4'h2)) : 5'h00;
        core_wr_sel <= s;
        core_long_wr_sel <= s[1:0];
        core_wr_bytes <= b;
        core_wr_data <= d[15:0];
        core_long_wr_data <= d;
        misc_data <= d[19:0];
        @(posedge ref_clk);
        core_wr_en <= 1'b0;
        core_long_wr_en <= 1'b0;
        misc_en <= 5'h00;
    endtask
endmodule // crs_core_model
`default_nettype wire

// File: tb/cpu_core_register_set_tb_top.sv
// Self-checking bench: AXI4-Lite register access and core-port writes.
// Assumes crs_core_model on the core port and crs_chk bound to the design.
`timescale 1ns/100ps
`default_nettype none
module cpu_core_register_set_tb_top;
    logic        ref_clk, reset, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr, a;
    logic [31:0] s_axi_wdata, d, m;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  core_rd_sel;
    wire logic   core_wr_en, core_long_wr_en, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic   s_axi_arready, s_axi_rvalid, register_bank;
    wire logic [1:0]  core_wr_bytes, core_long_wr_sel, s_axi_bresp, s_axi_rresp;
    wire logic [2:0]  core_wr_sel;
    wire logic [4:0]  misc_en;
    wire logic [10:0] cpu_flag_register;
    wire logic [15:0] core_wr_data, core_rd_data, active_stack_pointer;
    wire logic [19:0] frame_base_addr, static_base_addr, vector_table_base;
    wire logic [19:0] program_counter, misc_data;
    wire logic [31:0] core_long_wr_data, data_pair_low_long, data_pair_high_long;
    wire logic [31:0] address_pair_long, s_axi_rdata;
    int          err_total, check_count;
    crs_core_model core (.*);
    crs_register_set dut (.core_sp_wr_en(misc_en[0]), .core_sp_wr_data(misc_data[15:0]),
        .core_vector_wr_en(misc_en[1]), .core_vector_wr_data(misc_data),
        .core_pc_wr_en(misc_en[2]), .core_pc_wr_data(misc_data),
        .core_flag_wr_en(misc_en[3]), .core_flag_wr_data(misc_data[10:0]),
        .core_hw_int_ack(misc_en[4]), .*);
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task axw(input logic [11:0] ad, input logic [31:0] wd, input logic [3:0] st,
             input logic [1:0] er);
        s_axi_awaddr <= ad;
        s_axi_wdata <= wd;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task axr(input logic [11:0] ad, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task tally_and_finish;
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        err_total++;
        $display("Error at %0t: run timed out", $time);
        tally_and_finish;
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        {reset, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h18;
        {s_axi_arvalid, s_axi_rready, core_rd_sel} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        err_total = 0;
        check_count = 0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 14; i++)
            axr(12'(i * 4), 32'h0, 2'h0);
        for (int i = 0; i < 13; i++)
        begin
            a = 12'(i * 4);
            d = 32'hFEDCBA98 ^ {20'h0, a};
            m = (i == 8) ? 32'hFFFFF : (i == 12) ? 32'h7FF : 32'hFFFF;
            axw(a, d, 4'hF, (i == 9) ? 2'h2 : 2'h0);
            axr(a, (i == 9) ? 32'h0 : d & m, 2'h0);
        end
        axr(12'h034, 32'h0000BAB0, 2'h0);
        chk({31'h0, register_bank}, 32'h0);
        axw(12'h034, 32'h1, 4'hF, 2'h2);
        axw(12'h038, 32'h1, 4'hF, 2'h2);
        axr(12'h038, 32'h0, 2'h2);
        axw(12'h000, 32'h00000011, 4'h1, 2'h0);
        axr(12'h000, 32'h0000BA11, 2'h0);
        core.op(4'h0, 3'h0, 2'h1, 32'h1234);
        core_rd_sel <= 3'h0;
        #1 chk({16'h0, core_rd_data}, 32'hBA34);
        core.op(4'h0, 3'h1, 2'h2, 32'h5600);
        core.op(4'h0, 3'h3, 2'h3, 32'hC3C3);
        #1 chk(data_pair_high_long, 32'hC3C3569C);
        core.op(4'h1, 3'h0, 2'h0, 32'h11223344);
        core.op(4'h1, 3'h1, 2'h0, 32'h55667788);
        core.op(4'h1, 3'h3, 2'h0, 32'h99AABBCC);
        core.op(4'h1, 3'h2, 2'h0, 32'h0);
        #1 chk(data_pair_low_long, 32'h11223344);
        chk(data_pair_high_long, 32'h55667788);
        chk(address_pair_long, 32'h99AABBCC);
        axr(12'h008, 32'h00001122, 2'h0);
        core_rd_sel <= 3'h4;
        core.op(4'h0, 3'h6, 2'h3, 32'hFFFF);
        core.op(4'h0, 3'h7, 2'h3, 32'h8001);
        clk_en <= 1'b0;
        #1 chk({16'h0, core_rd_data}, 32'hBBCC);
        chk({12'h0, frame_base_addr}, 32'h0FFFF);
        chk({12'h0, static_base_addr}, 32'h08001);
        core.op(4'h0, 3'h7, 2'h3, 32'h1111);
        clk_en <= 1'b1;
        #1 chk({12'h0, static_base_addr}, 32'h08001);
        core.op(4'h3, 3'h0, 2'h0, 32'hFFFFF);
        core.op(4'h4, 3'h0, 2'h0, 32'hABCDE);
        #1 chk({12'h0, vector_table_base}, 32'hFFFFF);
        chk({12'h0, program_counter}, 32'hABCDE);
        axr(12'h024, 32'hABCDE, 2'h0);
        core.op(4'h5, 3'h0, 2'h0, 32'h010);
        core.op(4'h2, 3'h0, 2'h0, 32'h1357);
        #1 chk({31'h0, register_bank}, 32'h1);
        chk({16'h0, active_stack_pointer}, 32'h1357);
        axr(12'h02C, 32'h1357, 2'h0);
        axr(12'h028, 32'hBAB0, 2'h0);
        core.op(4'h5, 3'h0, 2'h0, 32'h090);
        #1 chk({16'h0, active_stack_pointer}, 32'hBAB0);
        core.op(4'h6, 3'h0, 2'h0, 32'h0);
        #1 chk({21'h0, cpu_flag_register}, 32'h010);
        chk({16'h0, active_stack_pointer}, 32'h1357);
        tally_and_finish;
    end
endmodule // cpu_core_register_set_tb_top
`default_nettype wire
